// file: hdl/idle_powerdown_params.svh
// Constants for the idle and power-down controller
`ifndef IDLE_POWERDOWN_PARAMS_SVH
`define IDLE_POWERDOWN_PARAMS_SVH
`define PWR_CTL_IDLE_BIT  0
`define PWR_CTL_PD_BIT    1
`define PWR_CTL_RESET     8'h00
`define PORT_RESET      8'hff
`define PWM_PORT_BIT    4
`define PWM_IDLE_LEVEL  1'b1
`endif

// file: hdl/idle_powerdown_pkg.sv
// Types for the idle and power-down controller
package idle_powerdown_pkg;
    typedef enum logic [1:0] {
        st_run,
        st_idle,
        st_powerdown
    } pmode_t;
    typedef struct packed {
        logic       we;
        logic [7:0] wdata;
    } pwr_ctl_wr_t;
    typedef struct packed {
        logic [4:0] p0;
        logic [7:0] p1;
        logic [7:0] p3;
    } port_bus_t;
endpackage : idle_powerdown_pkg

// file: hdl/clk_div2.sv
// Divide-by-two stage on the oscillator input
`timescale 1ns/10ps
module clk_div2 (
    input  wire logic clk,
    input  wire logic rst,
    output logic      clk_half_ff
);
    logic nxt_clk_half;
    always_comb
    begin
        nxt_clk_half = ~clk_half_ff;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            clk_half_ff <= 1'b0;
        else
            clk_half_ff <= nxt_clk_half;
    end
endmodule : clk_div2

// file: hdl/idle_powerdown_control.sv
// Idle and power-down mode control with clock gating and port retention
// What this block does
// - Oscillator input passes a divide-by-two flip-flop before internal clocking.
// - Idle stops CPU clock, peripherals run, ADC and PWM halt.
// - Idle keeps timer 0, serial interface with watchdog, interrupts running.
// - Requesting instruction completes; no further instruction runs before idle.
// - Idle keeps CPU state, RAM and special registers unchanged.
// - Enabled interrupt ends idle; execution resumes at its handler.
// - Hardware reset during idle restarts the processor like power-on.
// - Power-down stops the oscillator after requesting instruction completes.
// - Power-down preserves on-chip RAM contents, the power control register and latched port drive, except pulse output pin.
// - Only hardware reset leaves power-down; interrupts do not wake it.
// - Idle and power-down control bits live in power control register.
// - Ports keep driving latched data in both modes, except pulse output pin.
`timescale 1ns/10ps
`include "idle_powerdown_params.svh"
module idle_powerdown_control (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire idle_powerdown_pkg::pwr_ctl_wr_t pwr_ctl_wr,
    input  wire logic                          instr_done,
    input  wire logic                          irq_pending,
    input  wire idle_powerdown_pkg::port_bus_t port_latch,
    input  wire logic                          pwm_out,
    output logic                               cpu_clk_en_ff,
    output logic                               periph_clk_en_ff,
    output logic                               adc_pwm_clk_en_ff,
    output logic                               osc_en_ff,
    output logic                               ram_retain_ff,
    output logic                               irq_wake_ff,
    output logic                               clk_half_ff,
    output logic [7:0]                         power_control_register_ff,
    output idle_powerdown_pkg::port_bus_t      port_drive_ff
);
    import idle_powerdown_pkg::*;

    pmode_t     mode_ff;
    pmode_t     nxt_mode;
    logic [7:0] nxt_pwr_ctl;
    logic       nxt_cpu_en;
    logic       nxt_periph_en;
    logic       nxt_ap_en;
    logic       nxt_osc_en;
    logic       nxt_retain;
    logic       nxt_wake;
    port_bus_t  nxt_port;
    logic       pend_idle;
    logic       pend_pd;
    logic       clk_half;

    // Divided clock for internal circuitry
    clk_div2 i_clk_div2 (
        .clk         (clk),
        .rst         (rst),
        .clk_half_ff (clk_half)
    );

    function automatic logic bit_of(input logic [7:0] v, input int idx);
        bit_of = v[idx[2:0]];
    endfunction : bit_of

    // Mode and control register
    always_comb
    begin
        nxt_pwr_ctl = power_control_register_ff;
        nxt_mode    = mode_ff;
        nxt_wake    = 1'b0;
        if (pwr_ctl_wr.we && mode_ff == st_run)
            nxt_pwr_ctl = pwr_ctl_wr.wdata;
        pend_idle = bit_of(nxt_pwr_ctl, `PWR_CTL_IDLE_BIT);
        pend_pd   = bit_of(nxt_pwr_ctl, `PWR_CTL_PD_BIT);
        case (mode_ff)
            st_run:
            begin
                // Enter at the next instr_done once a mode bit is set; power-down wins over idle
                if (instr_done && pend_pd)
                    nxt_mode = st_powerdown;
                else if (instr_done && pend_idle)
                    nxt_mode = st_idle;
            end
            st_idle:
            begin
                if (irq_pending)
                begin
                    nxt_mode = st_run;
                    nxt_wake = 1'b1;
                    nxt_pwr_ctl[`PWR_CTL_IDLE_BIT] = 1'b0;
                end
            end
            st_powerdown:
            begin
                nxt_mode = st_powerdown;
            end
            default:
            begin
                nxt_mode = st_run;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_ff                   <= st_run;
            power_control_register_ff <= `PWR_CTL_RESET;
            irq_wake_ff               <= 1'b0;
        end
        else
        begin
            mode_ff                   <= nxt_mode;
            power_control_register_ff <= nxt_pwr_ctl;
            irq_wake_ff               <= nxt_wake;
        end
    end

    // Clock gates and port drive
    always_comb
    begin
        nxt_cpu_en    = (nxt_mode == st_run);
        nxt_periph_en = (nxt_mode != st_powerdown);
        nxt_ap_en     = (nxt_mode == st_run);
        nxt_osc_en    = (nxt_mode != st_powerdown);
        nxt_retain    = 1'b1;
        nxt_port      = port_latch;
        if (nxt_mode == st_run)
            nxt_port.p0[`PWM_PORT_BIT] = pwm_out;
        else
            nxt_port.p0[`PWM_PORT_BIT] = `PWM_IDLE_LEVEL;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cpu_clk_en_ff     <= 1'b1;
            periph_clk_en_ff  <= 1'b1;
            adc_pwm_clk_en_ff <= 1'b1;
            osc_en_ff         <= 1'b1;
            ram_retain_ff     <= 1'b1;
            port_drive_ff     <= {$bits(port_bus_t){1'b1}};
            clk_half_ff       <= 1'b0;
        end
        else
        begin
            cpu_clk_en_ff     <= nxt_cpu_en;
            periph_clk_en_ff  <= nxt_periph_en;
            adc_pwm_clk_en_ff <= nxt_ap_en;
            osc_en_ff         <= nxt_osc_en;
            ram_retain_ff     <= nxt_retain;
            port_drive_ff     <= nxt_port;
            clk_half_ff       <= clk_half;
        end
    end

    // Checks
    enter_pd_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_run && instr_done && pend_pd |=> mode_ff == st_powerdown ##1 !osc_en_ff)
        else $error("power-down not entered");
    pd_wins_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_run && instr_done && pend_pd && pend_idle |=> mode_ff != st_idle)
        else $error("idle beat power-down");
    enter_idle_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_run && instr_done && pend_idle && !pend_pd |=> !cpu_clk_en_ff && periph_clk_en_ff)
        else $error("idle gating wrong");
    idle_periph_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_idle |-> ##1 periph_clk_en_ff && osc_en_ff)
        else $error("peripherals stopped in idle");
    no_early_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_run && !instr_done |=> mode_ff == st_run)
        else $error("mode entered mid instruction");
    idle_wake_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_idle && irq_pending |=> mode_ff == st_run && irq_wake_ff ##1 cpu_clk_en_ff)
        else $error("interrupt did not wake idle");
    pd_stuck_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_powerdown |=> mode_ff == st_powerdown && !irq_wake_ff)
        else $error("power-down left without reset");
    reset_run_a: assert property (@(posedge clk)
        rst |=> mode_ff == st_run && power_control_register_ff == `PWR_CTL_RESET)
        else $error("reset did not restart");
    port_hold_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff != st_run |=> port_drive_ff.p3 == $past(port_latch.p3))
        else $error("port not retained");
    ctl_hold_a: assert property (@(posedge clk) disable iff (rst)
        mode_ff == st_idle && !irq_pending |=> $stable(power_control_register_ff))
        else $error("register changed in idle");

    cov_idle: cover property (@(posedge clk) mode_ff == st_idle ##1 mode_ff == st_run);
    cov_pd: cover property (@(posedge clk) mode_ff == st_powerdown);
    cov_both: cover property (@(posedge clk) mode_ff == st_run && instr_done && pend_pd && pend_idle);
endmodule : idle_powerdown_control

// file: verification/idle_powerdown_control_bench.sv
// Self-checking bench for the idle and power-down controller
`timescale 1ns/10ps
`include "idle_powerdown_params.svh"
module idle_powerdown_control_bench;
    import idle_powerdown_pkg::*;
    logic       clk;
    logic       rst;
    pwr_ctl_wr_t pwr_ctl_wr;
    logic       instr_done;
    logic       irq_pending;
    port_bus_t  port_latch;
    logic       pwm_out;
    logic       cpu_en;
    logic       per_en;
    logic       ap_en;
    logic       osc_en;
    logic       ram_en;
    logic       wake;
    logic       half;
    logic [7:0] pcr;
    port_bus_t  drive;
    int         num_errors;
    int         comparisons;
    int         cycles;

    idle_powerdown_control i_idle_powerdown_control (
        .clk                       (clk),
        .rst                       (rst),
        .pwr_ctl_wr                (pwr_ctl_wr),
        .instr_done                (instr_done),
        .irq_pending               (irq_pending),
        .port_latch                (port_latch),
        .pwm_out                   (pwm_out),
        .cpu_clk_en_ff             (cpu_en),
        .periph_clk_en_ff          (per_en),
        .adc_pwm_clk_en_ff         (ap_en),
        .osc_en_ff                 (osc_en),
        .ram_retain_ff             (ram_en),
        .irq_wake_ff               (wake),
        .clk_half_ff               (half),
        .power_control_register_ff (pcr),
        .port_drive_ff             (drive)
    );

    task automatic report_and_stop;
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Latched port data with the pulse pin replaced
    function automatic port_bus_t exp_p(input logic b4);
        port_bus_t p;
        p = port_latch;
        p.p0[`PWM_PORT_BIT] = b4;
        return p;
    endfunction : exp_p

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] v, input logic done);
        @(posedge clk);
        pwr_ctl_wr <= '{1'b1, v};
        instr_done <= done;
        @(posedge clk);
        pwr_ctl_wr.we <= 1'b0;
        instr_done <= 1'b0;
    endtask : wr

    task automatic t_half;
        logic a;
        tick(1);
        a = half;
        tick(1);
        chk(half, !a, "half clock");
        chk(drive, exp_p(pwm_out), "run ports");
    endtask : t_half

    task automatic t_idle;
        wr(8'h01, 1'b0);
        tick(3);
        chk({cpu_en, pcr}, {1'b1, 8'h01}, "no done");
        @(posedge clk);
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        tick(2);
        chk({cpu_en, per_en, ap_en, osc_en, ram_en}, 5'b01011, "idle en");
        chk(drive, exp_p(`PWM_IDLE_LEVEL), "idle ports");
        wr(8'h02, 1'b1);
        tick(3);
        chk({pcr, osc_en, cpu_en}, {8'h01, 2'b10}, "idle write");
        @(posedge clk);
        irq_pending <= 1'b1;
        tick(1);
        chk({wake, pcr}, {1'b1, 8'h00}, "wake");
        @(posedge clk);
        irq_pending <= 1'b0;
        #1;
        chk({wake, cpu_en}, 2'b01, "resume");
        tick(4);
        chk(ap_en, 1'b1, "adc clock after settle wait");
    endtask : t_idle

    task automatic t_idle_rst;
        wr(8'h01, 1'b1);
        tick(2);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({cpu_en, ap_en, pcr, drive}, {2'b11, 8'h00, 21'h1fffff}, "idle rst");
    endtask : t_idle_rst

    task automatic t_pdown;
        wr(8'h03, 1'b1);
        tick(2);
        chk({osc_en, cpu_en, per_en, ap_en, ram_en, pcr}, {5'b00001, 8'h03}, "pd");
        chk(drive, exp_p(`PWM_IDLE_LEVEL), "pd ports");
        @(posedge clk);
        irq_pending <= 1'b1;
        tick(4);
        chk({osc_en, wake}, 2'b00, "irq in pd");
        @(posedge clk);
        irq_pending <= 1'b0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({osc_en, cpu_en, pcr}, {2'b11, 8'h00}, "pd exit");
    endtask : t_pdown

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            report_and_stop;
        end
    end

    initial
    begin
        rst = 1'b1;
        pwr_ctl_wr = '0;
        instr_done = 1'b0;
        irq_pending = 1'b0;
        port_latch = '{5'h1a, 8'h5c, 8'ha3};
        pwm_out = 1'b0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({cpu_en, per_en, ap_en, osc_en, ram_en, wake, pcr}, {6'h3e, 8'h00}, "reset");
        chk(drive, 21'h1fffff, "reset ports");
        t_half;
        t_idle;
        t_idle_rst;
        t_pdown;
        report_and_stop;
    end
endmodule : idle_powerdown_control_bench
